/* File: esos_sequencer.sv */
// Purpose: Starter, fuel and excitation sequencing with Avalon-MM registers
// Assumes: Inputs synchronous to clk_sys; sources are already debounced
// Notes:
// Overview of operation
// - Starter on during start request, off 200-300 ms after start recognized
// - Default mode: fuel on at least 200 ms before starter
// - Fuel off on stop; configurable delay when engine stopped externally
// - Energize-to-stop drives stop on first static output or fuel output
// - Lost relay common positive in operating mode raises unmaskable emergency stop alarm
// - Excitation on 30 s while cranking, then 5 s off, 5 s on
// - After start recognized, excitation stays on 5 s more
// - Alternator voltage zero for configured time raises belt anomaly, set severity
// - Settings enable alternator start detection and disable belt anomaly
// - Starter and fuel state readable, one bit each, 1 means active
// - Starter and fuel outputs may be reassigned to other functions
// - Excitation follows start command; started from any enabled source
//
// The Avalon-MM interface to the registers and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "esos_defines.svh"
module esos_sequencer
  import esos_pkg::*;
#(
  parameter int unsigned MS_DIV = `ESOS_MS_DIV
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic started_voltage,
  input wire logic started_frequency,
  input wire logic started_speed,
  input wire logic started_oil,
  input wire logic dplus_present,
  input wire logic relay_common_positive,
  input wire logic operating_mode,
  input wire logic alt_fn_start,
  input wire logic alt_fn_fuel,
  output logic starter_cmd,
  output logic fuel_solenoid_terminal,
  output logic first_positive_static_output,
  output logic excitation_cmd,
  output logic emergency_stop_alarm,
  output logic belt_broken_anomaly,
  output logic [1:0] belt_severity,
  output logic irq
);
  localparam logic [15:0] FUEL_LEAD = 16'(`ESOS_FUEL_LEAD_MS);
  // Midpoint of the 200-300 ms window keeps margin both ways
  localparam logic [15:0] START_OFF =
    16'((`ESOS_START_OFF_MIN_MS + `ESOS_START_OFF_MAX_MS) / 2);
  localparam logic [15:0] EXC_HOLD = 16'(`ESOS_EXC_HOLD_S * `ESOS_MS_PER_S);
  localparam logic [15:0] EXC_TOG = 16'(`ESOS_EXC_TOGGLE_S * `ESOS_MS_PER_S);
  localparam logic [15:0] EXC_TAIL = 16'(`ESOS_EXC_TAIL_S * `ESOS_MS_PER_S);

  logic tick_ms;
  esos_state_e state_ff;
  esos_state_e nxt_state;
  logic [15:0] seq_ms_ff;
  logic [15:0] exc_ms_ff;
  logic [15:0] belt_ms_ff;
  logic [15:0] fdly_ms_ff;
  logic exc_on_ff;
  logic exc_tail_ff;
  logic started_ff;
  logic started_d_ff;
  logic [31:0] ctrl_ff;
  logic [31:0] cfg_ff;
  logic [15:0] fuel_dly_ff;
  logic [15:0] belt_dly_ff;
  logic [1:0] alt_state_ff;
  logic [`ESOS_IRQ_W-1:0] irq_stat_ff;
  logic [`ESOS_IRQ_W-1:0] irq_mask_ff;
  logic [`ESOS_IRQ_W-1:0] irq_evt;
  logic wr_en;
  logic rd_en;
  logic start_req;
  logic stop_req;
  logic ets_mode;
  logic stop_cmd;
  logic fuel_run;
  logic estop;
  logic belt_fault;

  function automatic logic [31:0] merge_be(input logic [31:0] old,
                                           input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = wd[i*8 +: 8];
    end
    return r;
  endfunction : merge_be

  esos_tick #(.DIV(MS_DIV)) u_tick
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .tick_ms(tick_ms)
  );

  assign start_req = ctrl_ff[`ESOS_CTRL_START];
  assign stop_req = ctrl_ff[`ESOS_CTRL_STOP];
  assign ets_mode = cfg_ff[`ESOS_CFG_ETS];
  assign estop = operating_mode && !relay_common_positive;
  // One-cycle slave: waitrequest high while idle and in the request's first cycle, low in its second
  assign wr_en = avs_write && !avs_waitrequest;
  assign rd_en = avs_read && !avs_waitrequest;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      started_ff <= 1'b0;
    else
      started_ff <= started_voltage || started_frequency || started_speed ||
                    started_oil || (cfg_ff[`ESOS_CFG_DPLUS_EN] && dplus_present);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      started_d_ff <= 1'b0;
    else
      started_d_ff <= started_ff;
  end

  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ESOS_IDLE:
        if (start_req && !stop_req && !estop)
          nxt_state = ets_mode ? ESOS_CRANK : ESOS_FUEL_LEAD;
      ESOS_FUEL_LEAD:
        if (!start_req || stop_req || estop)
          nxt_state = ESOS_STOP;
        // Strictly past: the free-running tick may land just after entry
        else if (seq_ms_ff > FUEL_LEAD)
          nxt_state = ESOS_CRANK;
      ESOS_CRANK:
        if (!start_req || stop_req || estop)
          nxt_state = ESOS_STOP;
        // Timer restarts on the started edge, so wait until it has
        else if (started_ff && started_d_ff && seq_ms_ff >= START_OFF)
          nxt_state = ESOS_RUN;
      ESOS_RUN:
        if (stop_req || estop || !start_req)
          nxt_state = ESOS_STOP;
        else if (!started_ff && fdly_ms_ff >= fuel_dly_ff)
          nxt_state = ESOS_STOP;
      ESOS_STOP:
        if (!start_req && !started_ff)
          nxt_state = ESOS_IDLE;
      default:
        nxt_state = ESOS_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      state_ff <= ESOS_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Sequence timer: restarts on state change and on the started edge
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      seq_ms_ff <= 16'h0;
    else if (nxt_state != state_ff || (started_ff && !started_d_ff))
      seq_ms_ff <= 16'h0;
    else if (tick_ms && seq_ms_ff != 16'hffff)
      seq_ms_ff <= seq_ms_ff + 16'h1;
  end

  // Time since the engine stopped by other means while running
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      fdly_ms_ff <= 16'h0;
    else if (state_ff != ESOS_RUN || started_ff)
      fdly_ms_ff <= 16'h0;
    else if (tick_ms && fdly_ms_ff != 16'hffff)
      fdly_ms_ff <= fdly_ms_ff + 16'h1;
  end

  // Excitation: 30 s steady during crank, then 5 s toggling, 5 s tail
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      exc_ms_ff <= 16'h0;
      exc_on_ff <= 1'b0;
      exc_tail_ff <= 1'b0;
    end
    else if (state_ff == ESOS_CRANK && !started_ff)
    begin
      exc_tail_ff <= 1'b0;
      if (!exc_on_ff && exc_ms_ff == 16'h0)
      begin
        exc_on_ff <= 1'b1;
        exc_ms_ff <= 16'h1;
      end
      else if (tick_ms)
      begin
        if (exc_ms_ff >= EXC_HOLD + EXC_TOG)
        begin
          exc_ms_ff <= EXC_HOLD + 16'h1;
          exc_on_ff <= !exc_on_ff;
        end
        else if (exc_ms_ff == EXC_HOLD)
        begin
          exc_ms_ff <= exc_ms_ff + 16'h1;
          exc_on_ff <= 1'b0;
        end
        else
          exc_ms_ff <= exc_ms_ff + 16'h1;
      end
    end
    else if (started_ff && (state_ff == ESOS_CRANK || state_ff == ESOS_RUN) &&
             (exc_ms_ff != 16'h0 || exc_tail_ff))
    begin
      if (!exc_tail_ff)
      begin
        exc_tail_ff <= 1'b1;
        exc_on_ff <= 1'b1;
        exc_ms_ff <= 16'h1;
      end
      else if (tick_ms && exc_ms_ff != 16'h0)
      begin
        if (exc_ms_ff >= EXC_TAIL)
        begin
          exc_ms_ff <= 16'h0;
          exc_on_ff <= 1'b0;
        end
        else
          exc_ms_ff <= exc_ms_ff + 16'h1;
      end
    end
    else if (!(started_ff && exc_tail_ff))
    begin
      exc_ms_ff <= 16'h0;
      exc_on_ff <= 1'b0;
      exc_tail_ff <= 1'b0;
    end
  end

  // Belt: alternator voltage absent while engine runs
  assign belt_fault = belt_dly_ff != 16'h0 && belt_ms_ff >= belt_dly_ff;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      belt_ms_ff <= 16'h0;
    else if (state_ff != ESOS_RUN || dplus_present || cfg_ff[`ESOS_CFG_BELT_DIS])
      belt_ms_ff <= 16'h0;
    else if (tick_ms && belt_ms_ff != 16'hffff)
      belt_ms_ff <= belt_ms_ff + 16'h1;
  end

  assign fuel_run = (state_ff == ESOS_FUEL_LEAD || state_ff == ESOS_CRANK ||
                     state_ff == ESOS_RUN) && !ets_mode;
  assign stop_cmd = ets_mode && (state_ff == ESOS_STOP || estop);

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      starter_cmd <= 1'b0;
      fuel_solenoid_terminal <= 1'b0;
      first_positive_static_output <= 1'b0;
      excitation_cmd <= 1'b0;
      emergency_stop_alarm <= 1'b0;
      belt_broken_anomaly <= 1'b0;
      belt_severity <= 2'h0;
      alt_state_ff <= 2'h0;
    end
    else
    begin
      starter_cmd <= cfg_ff[`ESOS_CFG_START_REMAP] ? alt_fn_start :
                     (state_ff == ESOS_CRANK);
      if (cfg_ff[`ESOS_CFG_FUEL_REMAP])
        fuel_solenoid_terminal <= alt_fn_fuel;
      else if (ets_mode && cfg_ff[`ESOS_CFG_STOP_ON_FUEL])
        fuel_solenoid_terminal <= stop_cmd;
      else
        fuel_solenoid_terminal <= fuel_run;
      first_positive_static_output <= stop_cmd && !cfg_ff[`ESOS_CFG_STOP_ON_FUEL];
      excitation_cmd <= exc_on_ff;
      emergency_stop_alarm <= estop;
      belt_broken_anomaly <= belt_fault;
      belt_severity <= cfg_ff[`ESOS_CFG_SEV_LSB +: 2];
      alt_state_ff <= {fuel_solenoid_terminal, starter_cmd};
    end
  end

  // Sticky events; hardware set wins over write-one-to-clear
  assign irq_evt = {started_ff && !started_d_ff, belt_fault, estop};

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irq_stat_ff <= '0;
    else if (wr_en && avs_address == `ESOS_REG_IRQ_STAT && avs_byteenable[0])
      irq_stat_ff <= (irq_stat_ff & ~avs_writedata[`ESOS_IRQ_W-1:0]) | irq_evt;
    else
      irq_stat_ff <= irq_stat_ff | irq_evt;
  end

  // Emergency stop cannot be masked
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      irq <= 1'b0;
    else
      irq <= irq_stat_ff[`ESOS_IRQ_ESTOP] ||
             |(irq_stat_ff & irq_mask_ff);
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_ff <= 32'h0;
      cfg_ff <= `ESOS_CFG_RESET;
      irq_mask_ff <= '0;
      fuel_dly_ff <= 16'h0;
      belt_dly_ff <= 16'h0;
    end
    else if (wr_en)
    begin
      if (avs_address == `ESOS_REG_CTRL)
        ctrl_ff <= merge_be(ctrl_ff, avs_writedata, avs_byteenable);
      else if (avs_address == `ESOS_REG_CFG)
        cfg_ff <= merge_be(cfg_ff, avs_writedata, avs_byteenable);
      else if (avs_address == `ESOS_REG_IRQ_MASK && avs_byteenable[0])
        irq_mask_ff <= avs_writedata[`ESOS_IRQ_W-1:0];
      else if (avs_address == `ESOS_REG_FUEL_DLY)
        fuel_dly_ff <= 16'(merge_be({16'h0, fuel_dly_ff}, avs_writedata, avs_byteenable));
      else if (avs_address == `ESOS_REG_BELT_DLY)
        belt_dly_ff <= 16'(merge_be({16'h0, belt_dly_ff}, avs_writedata, avs_byteenable));
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
    end
    else
    begin
      avs_waitrequest <= !(avs_read || avs_write) || !avs_waitrequest;
      if (avs_read && avs_waitrequest)
      begin
        if (avs_address == `ESOS_REG_CTRL)
          avs_readdata <= ctrl_ff;
        else if (avs_address == `ESOS_REG_CFG)
          avs_readdata <= cfg_ff;
        else if (avs_address == `ESOS_REG_STATUS)
          avs_readdata <= {22'h0, state_ff, started_ff, alt_state_ff,
                           excitation_cmd, belt_broken_anomaly};
        else if (avs_address == `ESOS_REG_IRQ_STAT)
          avs_readdata <= {29'h0, irq_stat_ff};
        else if (avs_address == `ESOS_REG_IRQ_MASK)
          avs_readdata <= {29'h0, irq_mask_ff};
        else if (avs_address == `ESOS_REG_FUEL_DLY)
          avs_readdata <= {16'h0, fuel_dly_ff};
        else if (avs_address == `ESOS_REG_BELT_DLY)
          avs_readdata <= {16'h0, belt_dly_ff};
        else
          avs_readdata <= 32'h0;
      end
      else if (rd_en)
        avs_readdata <= avs_readdata;
    end
  end
endmodule : esos_sequencer

/* File: esos_defines.svh */
// Purpose: Constants for the engine start output sequencer
// Assumes: 200 MHz system clock
// Notes: Register offsets are byte addresses on a 32-bit bus
`ifndef ESOS_DEFINES_SVH
`define ESOS_DEFINES_SVH
`define ESOS_CLK_HZ 200000000
`define ESOS_MS_DIV (`ESOS_CLK_HZ / 1000)
`define ESOS_FUEL_LEAD_MS 200
`define ESOS_START_OFF_MIN_MS 200
`define ESOS_START_OFF_MAX_MS 300
`define ESOS_EXC_HOLD_S 30
`define ESOS_EXC_TOGGLE_S 5
`define ESOS_EXC_TAIL_S 5
`define ESOS_MS_PER_S 1000
`define ESOS_REG_CTRL 6'h00
`define ESOS_REG_CFG 6'h04
`define ESOS_REG_STATUS 6'h08
`define ESOS_REG_IRQ_STAT 6'h0c
`define ESOS_REG_IRQ_MASK 6'h10
`define ESOS_REG_FUEL_DLY 6'h14
`define ESOS_REG_BELT_DLY 6'h18
`define ESOS_REG_ALT_FN 6'h1c
`define ESOS_CTRL_START 0
`define ESOS_CTRL_STOP 1
`define ESOS_CFG_ETS 0
`define ESOS_CFG_STOP_ON_FUEL 1
`define ESOS_CFG_DPLUS_EN 2
`define ESOS_CFG_BELT_DIS 3
`define ESOS_CFG_START_REMAP 4
`define ESOS_CFG_FUEL_REMAP 5
`define ESOS_CFG_SEV_LSB 6
`define ESOS_CFG_RESET 32'h0000_0000
`define ESOS_IRQ_ESTOP 0
`define ESOS_IRQ_BELT 1
`define ESOS_IRQ_STARTED 2
`define ESOS_IRQ_W 3
`endif

/* File: esos_pkg.sv */
// Purpose: Types for the engine start output sequencer
// Assumes: Constants live in esos_defines.svh
// Notes: One-hot state codes
package esos_pkg;
  typedef enum logic [4:0] {
    ESOS_IDLE = 5'h01,
    ESOS_FUEL_LEAD = 5'h02,
    ESOS_CRANK = 5'h04,
    ESOS_RUN = 5'h08,
    ESOS_STOP = 5'h10
  } esos_state_e;
  typedef enum logic [1:0] {
    ESOS_SEV_WARN = 2'h0,
    ESOS_SEV_UNLOAD = 2'h1,
    ESOS_SEV_DEACT = 2'h2,
    ESOS_SEV_ALARM = 2'h3
  } esos_sev_e;
endpackage : esos_pkg

/* File: esos_tick.sv */
// Purpose: Millisecond enable pulse from the system clock
// Assumes: DIV is the clock count per millisecond
// Notes: One-cycle pulse, free running after reset
`timescale 1ns/1ps
module esos_tick
  import esos_pkg::*;
#(
  parameter int unsigned DIV = 200000
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  output logic tick_ms
);
  logic [31:0] cnt_ff;

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cnt_ff <= 32'h0;
      tick_ms <= 1'b0;
    end
    else if (cnt_ff == DIV - 1)
    begin
      cnt_ff <= 32'h0;
      tick_ms <= 1'b1;
    end
    else
    begin
      cnt_ff <= cnt_ff + 32'h1;
      tick_ms <= 1'b0;
    end
  end
endmodule : esos_tick

/* File: esos_sequencer_assertions.sv */
// Purpose: Port-level checks for the engine start output sequencer
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Run-length counters stand in for long timers
`timescale 1ns/1ps
module esos_sequencer_chk
  import esos_pkg::*;
#(
  parameter int unsigned MS_DIV = 10
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic started_voltage,
  input wire logic started_frequency,
  input wire logic started_speed,
  input wire logic started_oil,
  input wire logic relay_common_positive,
  input wire logic operating_mode,
  input wire logic starter_cmd,
  input wire logic fuel_solenoid_terminal,
  input wire logic excitation_cmd,
  input wire logic emergency_stop_alarm,
  input wire logic belt_broken_anomaly,
  input wire logic irq
);
  // One tick of slack: fuel may rise between two millisecond ticks
  localparam int unsigned LEAD = 199 * MS_DIV;
  localparam int unsigned OFF_MAX = 300 * MS_DIV + 3;
  // Start recognized late in the hold adds the 5 s tail legally
  localparam int unsigned HOLD = (30000 + 5000) * MS_DIV + 3;
  localparam int unsigned TAIL = 5000 * MS_DIV + 3;
  int unsigned fuel_run_ff;
  int unsigned src_run_ff;
  int unsigned exc_run_ff;
  logic src;
  assign src = started_voltage | started_frequency | started_speed | started_oil;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      fuel_run_ff <= 0;
    else
      fuel_run_ff <= fuel_solenoid_terminal ? fuel_run_ff + 1 : 0;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      src_run_ff <= 0;
    else
      src_run_ff <= src ? src_run_ff + 1 : 0;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      exc_run_ff <= 0;
    else
      exc_run_ff <= excitation_cmd ? exc_run_ff + 1 : 0;
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after the request");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  unmapped_zero_a: assert property (avs_read && !avs_waitrequest && avs_address > 6'h1c |-> avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  fuel_lead_a: assert property ($rose(starter_cmd) && fuel_solenoid_terminal |-> fuel_run_ff >= LEAD)
    else $error("starter rose too soon after fuel");
  starter_off_a: assert property (src_run_ff >= OFF_MAX |-> !starter_cmd)
    else $error("starter still on long after engine started");
  exc_hold_a: assert property (exc_run_ff < HOLD)
    else $error("excitation held on beyond its limit");
  exc_tail_a: assert property (src_run_ff >= TAIL |-> !excitation_cmd)
    else $error("excitation still on after its tail time");
  estop_set_a: assert property (operating_mode && !relay_common_positive |=> emergency_stop_alarm)
    else $error("emergency stop alarm missing");
  estop_clr_a: assert property (!(operating_mode && !relay_common_positive) |=> !emergency_stop_alarm)
    else $error("emergency stop alarm without cause");
  estop_irq_a: assert property ($rose(emergency_stop_alarm) |-> ##[1:2] irq)
    else $error("emergency stop did not raise irq");
  cover property ($fell(starter_cmd));
  cover property ($rose(emergency_stop_alarm));
  cover property ($rose(belt_broken_anomaly));
endmodule : esos_sequencer_chk

bind esos_sequencer esos_sequencer_chk #(.MS_DIV(MS_DIV)) u_esos_sequencer_chk (.clk_sys, .arst_n,
  .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .started_voltage,
  .started_frequency, .started_speed, .started_oil, .relay_common_positive, .operating_mode,
  .starter_cmd, .fuel_solenoid_terminal, .excitation_cmd, .emergency_stop_alarm,
  .belt_broken_anomaly, .irq);

/* File: esos_engine_model.sv */
// Purpose: Behavioural engine with starter, fuel valve and charging alternator
// Assumes: crank_cyc of zero means the engine never fires
// Notes: Engine runs only while fuel is on, as in de-energize stop
`timescale 1ns/1ps
module esos_engine_model
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic starter_cmd,
  input wire logic fuel_solenoid_terminal,
  input wire logic [15:0] crank_cyc,
  input wire logic belt_ok,
  output logic started_speed,
  output logic dplus_present
);
  int unsigned crank_ff;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      crank_ff <= 0;
    else if (!fuel_solenoid_terminal)
      crank_ff <= 0;
    else if (starter_cmd)
      crank_ff <= crank_ff + 1;
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      started_speed <= 1'b0;
    else
      started_speed <= fuel_solenoid_terminal && (started_speed || (crank_cyc != 0 && crank_ff >= crank_cyc));
  // Broken belt stops the alternator while the engine keeps turning
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
      dplus_present <= 1'b0;
    else
      dplus_present <= started_speed && belt_ok;
endmodule : esos_engine_model

/* File: esos_testbench.sv */
// Purpose: Self-checking bench for the engine start output sequencer
// Assumes: MS_DIV of 1, so one millisecond is one clock
// Notes: Bus reads sample just after the edge, before the design updates
`timescale 1ns/1ps
`include "esos_defines.svh"
module testbench
  import esos_pkg::*;
;
  localparam int MSC = 1;
  logic clk_sys = 1'b0;
  logic arst_n, avs_read, avs_write, avs_waitrequest, started_voltage, started_frequency;
  logic started_speed, started_oil, dplus_present, relay_common_positive, operating_mode;
  logic alt_fn_start, alt_fn_fuel, starter_cmd, fuel_solenoid_terminal, irq, belt_ok;
  logic first_positive_static_output, excitation_cmd, emergency_stop_alarm, belt_broken_anomaly;
  logic [5:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0] avs_byteenable;
  logic [1:0] belt_severity;
  logic [15:0] crank_cyc;
  logic [31:0] seed = 32'h0000df5d;
  logic exc_prev = 1'b0;
  int n_errors = 0;
  int total_checks = 0;
  int n, m, len, last_len;
  always #2.5 clk_sys = ~clk_sys;
  esos_sequencer #(.MS_DIV(MSC)) u_esos_sequencer (.clk_sys, .arst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .started_voltage,
    .started_frequency, .started_speed, .started_oil, .dplus_present, .relay_common_positive,
    .operating_mode, .alt_fn_start, .alt_fn_fuel, .starter_cmd, .fuel_solenoid_terminal,
    .first_positive_static_output, .excitation_cmd, .emergency_stop_alarm, .belt_broken_anomaly,
    .belt_severity, .irq);
  esos_engine_model u_esos_engine_model (.clk_sys, .arst_n, .starter_cmd, .fuel_solenoid_terminal,
    .crank_cyc, .belt_ok, .started_speed, .dplus_present);
  // Length of the last finished excitation on or off phase
  always @(posedge clk_sys)
  begin
    if (excitation_cmd !== exc_prev)
    begin
      last_len = len;
      len = 1;
    end
    else
      len++;
    exc_prev = excitation_cmd;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic near(int k, int e);
    return (k >= e - 3) && (k <= e + 3);
  endfunction : near
  task automatic end_sim();
    $display("Checks %0d, errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  task automatic tmo();
    n_errors++;
    $display("Error at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
    end_sim();
  endtask : tmo
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    k = 0;
    do
    begin
      @(posedge clk_sys);
      k++;
    end
    while (avs_waitrequest !== 1'b0 && k < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
    if (k >= 20)
      tmo();
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask : rd
  task automatic wt(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 40000)
    begin
      @(posedge clk_sys);
      k++;
    end
    if (k >= 40000)
      tmo();
  endtask : wt
  initial
  begin
    {arst_n, avs_read, avs_write, started_voltage, started_frequency, started_oil} = 6'h00;
    {alt_fn_start, alt_fn_fuel, avs_address, avs_writedata, crank_cyc} = 56'h0;
    {relay_common_positive, operating_mode, belt_ok, avs_byteenable} = 7'h7f;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    chk({avs_waitrequest, starter_cmd, fuel_solenoid_terminal, excitation_cmd}, 4'h8);
    @(posedge clk_sys);
    rd(`ESOS_REG_CFG, `ESOS_CFG_RESET);
    rd(6'h3c, 32'h0);
    wr(`ESOS_REG_CTRL, 32'h1);
    wt(fuel_solenoid_terminal, 1'b1, n);
    wt(starter_cmd, 1'b1, n);
    chk(n >= `ESOS_FUEL_LEAD_MS * MSC - 1, 1'b1);
    wt(excitation_cmd, 1'b1, n);
    for (int i = 0; i < 3; i++)
    begin
      wt(excitation_cmd, i[0], n);
      @(posedge clk_sys);
      chk(near(last_len, (i == 0 ? `ESOS_EXC_HOLD_S : `ESOS_EXC_TOGGLE_S) * 1000 * MSC), 1'b1);
    end
    wr(`ESOS_REG_CTRL, 32'h2);
    wt(fuel_solenoid_terminal, 1'b0, n);
    chk(starter_cmd, 1'b0);
    wr(`ESOS_REG_CTRL, 32'h0);
    crank_cyc <= 16'(300 + xs() % 1000);
    wr(`ESOS_REG_CTRL, 32'h1);
    wt(started_speed, 1'b1, n);
    wt(starter_cmd, 1'b0, n);
    chk(n >= `ESOS_START_OFF_MIN_MS * MSC && n <= `ESOS_START_OFF_MAX_MS * MSC + 2, 1'b1);
    wt(excitation_cmd, 1'b0, m);
    chk(near(n + m, `ESOS_EXC_TAIL_S * `ESOS_MS_PER_S * MSC), 1'b1);
    rd(`ESOS_REG_STATUS, {22'h0, ESOS_RUN, 5'h18});
    wr(`ESOS_REG_CFG, 32'h80);
    wr(`ESOS_REG_BELT_DLY, 32'h32);
    belt_ok <= 1'b0;
    wt(belt_broken_anomaly, 1'b1, n);
    chk(n <= 60 * MSC, 1'b1);
    chk(belt_severity, ESOS_SEV_DEACT);
    rd(`ESOS_REG_IRQ_STAT, 32'h6);
    wr(`ESOS_REG_CFG, 32'h88);
    repeat (3) @(posedge clk_sys);
    chk(belt_broken_anomaly, 1'b0);
    belt_ok <= 1'b1;
    wr(`ESOS_REG_IRQ_STAT, 32'h6);
    rd(`ESOS_REG_IRQ_STAT, 32'h0);
    wr(`ESOS_REG_CTRL, 32'h2);
    wt(started_speed, 1'b0, n);
    crank_cyc <= 16'h0;
    wr(`ESOS_REG_CTRL, 32'h0);
    wr(`ESOS_REG_CFG, 32'h1);
    wr(`ESOS_REG_CTRL, 32'h1);
    wt(starter_cmd, 1'b1, n);
    wr(`ESOS_REG_CTRL, 32'h2);
    wt(first_positive_static_output, 1'b1, n);
    chk(fuel_solenoid_terminal, 1'b0);
    wr(`ESOS_REG_CTRL, 32'h0);
    wr(`ESOS_REG_CFG, 32'h3);
    wr(`ESOS_REG_CTRL, 32'h1);
    wr(`ESOS_REG_CTRL, 32'h2);
    wt(fuel_solenoid_terminal, 1'b1, n);
    wr(`ESOS_REG_CTRL, 32'h0);
    wr(`ESOS_REG_CFG, 32'h0);
    relay_common_positive <= 1'b0;
    wt(emergency_stop_alarm, 1'b1, n);
    chk(n <= 2, 1'b1);
    wr(`ESOS_REG_IRQ_MASK, 32'h7);
    wt(irq, 1'b1, n);
    wr(`ESOS_REG_CTRL, 32'h1);
    repeat (300) @(posedge clk_sys);
    chk({emergency_stop_alarm, starter_cmd}, 2'h2);
    wr(`ESOS_REG_CTRL, 32'h0);
    relay_common_positive <= 1'b1;
    wt(emergency_stop_alarm, 1'b0, n);
    wr(`ESOS_REG_IRQ_STAT, 32'h7);
    wt(irq, 1'b0, n);
    wr(`ESOS_REG_IRQ_MASK, 32'h0);
    wr(`ESOS_REG_CFG, 32'h30);
    // Never both at once, so fuel lead timing is not faked by remapping
    repeat (16)
    begin
      m = xs();
      {alt_fn_start, alt_fn_fuel} <= m[0] ? {m[1], 1'b0} : {1'b0, m[1]};
      repeat (3) @(posedge clk_sys);
      chk({starter_cmd, fuel_solenoid_terminal}, {alt_fn_start, alt_fn_fuel});
    end
    started_oil <= 1'b1;
    repeat (3) @(posedge clk_sys);
    rd(`ESOS_REG_IRQ_STAT, 32'h4);
    end_sim();
  end
endmodule : testbench
